// *** register_window_decoder_consts.svh ***
// Purpose: Address map and window-select constants for the register window decoder.
// Assumes: 16-bit byte addresses and an 8-bit window select value.
// Notes: Window codes are compared with bit 7 of the select value removed.
`ifndef REGISTER_WINDOW_DECODER_CONSTS_SVH
`define REGISTER_WINDOW_DECODER_CONSTS_SVH

`define ADDR_WIDTH 16
`define WSEL_WIDTH 8
`define SFR_LAST 16'h0017
`define RAM_FIRST 16'h0018
`define RAM_LAST 16'h03FF
`define EXT_LOW_FIRST 16'h0400
`define EXT_LOW_LAST 16'h1FFD
`define PORT34_FIRST 16'h1FFE
`define PROG_FIRST 16'h2000
`define PROG_LAST 16'h9FFF
`define EXT_HIGH_FIRST 16'hA000
`define LOWER_FILE_PAGE 8'h00
`define WIN128_CODE 4'h2
`define WIN64_CODE 3'h2
`define WIN32_CODE 2'h2
`define WIN128_BASE 8'h80
`define WIN64_BASE 8'hC0
`define WIN32_BASE 8'hE0

`endif

// *** register_window_decoder_pkg.sv ***
// Purpose: Types shared by the register window decoder and its checks.
// Assumes: Nothing beyond the constants header.
// Notes: Targets are one-hot so that each output bit can drive a select directly.
package register_window_decoder_pkg;

    typedef enum logic [4:0] {
        TGT_SFR = 5'h01,
        TGT_RAM = 5'h02,
        TGT_PORT34 = 5'h04,
        TGT_PROG = 5'h08,
        TGT_EXT = 5'h10
    } target_t;

endpackage : register_window_decoder_pkg

// *** register_window_decoder.sv ***
// Purpose: Remaps lower-file windows into register RAM and steers each address to its target.
// Assumes: Requests and the window select come from the core clock domain;
//          external_access_select is a pin and is synchronised here.
// Notes: One cycle from request to registered answer.
`timescale 1ns/10ps
`include "register_window_decoder_consts.svh"

module register_window_decoder #(
    parameter int ADDR_W = `ADDR_WIDTH
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [7:0] window_select_value,
    input wire logic external_access_select,
    input wire logic req_valid,
    input wire logic [15:0] req_addr,
    input wire logic req_fetch,
    output logic resp_valid,
    output logic [15:0] resp_addr,
    output register_window_decoder_pkg::target_t resp_target,
    output logic resp_remapped
);

    if (ADDR_W != 16)
    begin : g_bad_width
        $error("register_window_decoder serves 16-bit addresses only");
    end

    // Steers a final address to its target. The program range is split by the pin level.
    function automatic register_window_decoder_pkg::target_t target_of(
        input logic [15:0] addr,
        input logic ext_sel,
        input logic fetch
    );
        register_window_decoder_pkg::target_t t;
        t = register_window_decoder_pkg::TGT_EXT;
        if (fetch && addr <= `RAM_LAST)
            t = register_window_decoder_pkg::TGT_EXT;
        else if (addr <= `SFR_LAST)
            t = register_window_decoder_pkg::TGT_SFR;
        else if (addr <= `RAM_LAST)
            t = register_window_decoder_pkg::TGT_RAM;
        else if (addr <= `EXT_LOW_LAST)
            t = register_window_decoder_pkg::TGT_EXT;
        else if (addr < `PROG_FIRST)
            t = register_window_decoder_pkg::TGT_PORT34;
        else if (addr <= `PROG_LAST)
            t = ext_sel ? register_window_decoder_pkg::TGT_PROG
                        : register_window_decoder_pkg::TGT_EXT;
        else
            t = register_window_decoder_pkg::TGT_EXT;
        return t;
    endfunction : target_of

    logic ext_meta_reg;
    logic ext_sync_reg;
    logic resp_valid_next;
    logic [15:0] resp_addr_next;
    register_window_decoder_pkg::target_t resp_target_next;
    logic resp_remapped_next;
    logic [6:0] wsel;
    logic lower_data;

    // The pin may change at any time, so only the second stage is ever decoded.
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ext_meta_reg <= 1'b0;
            ext_sync_reg <= 1'b0;
        end
        else
        begin
            ext_meta_reg <= external_access_select;
            ext_sync_reg <= ext_meta_reg;
        end
    end

    always_comb
    begin
        wsel = window_select_value[6:0];
        // Fetches are never windowed: they leave the chip anyway.
        lower_data = !req_fetch && (req_addr[15:8] == `LOWER_FILE_PAGE);
        resp_valid_next = req_valid;
        resp_addr_next = req_addr;
        resp_remapped_next = 1'b0;
        if (lower_data && wsel[6:3] == `WIN128_CODE && req_addr[7:0] >= `WIN128_BASE)
        begin
            resp_addr_next = {6'h00, wsel[2:0], req_addr[6:0]};
            resp_remapped_next = 1'b1;
        end
        else if (lower_data && wsel[6:4] == `WIN64_CODE && req_addr[7:0] >= `WIN64_BASE)
        begin
            resp_addr_next = {6'h00, wsel[3:0], req_addr[5:0]};
            resp_remapped_next = 1'b1;
        end
        else if (lower_data && wsel[6:5] == `WIN32_CODE && req_addr[7:0] >= `WIN32_BASE)
        begin
            resp_addr_next = {6'h00, wsel[4:0], req_addr[4:0]};
            resp_remapped_next = 1'b1;
        end
        resp_target_next = target_of(resp_addr_next, ext_sync_reg, req_fetch);
    end

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            resp_valid <= 1'b0;
            resp_addr <= 16'h0000;
            resp_target <= register_window_decoder_pkg::TGT_EXT;
            resp_remapped <= 1'b0;
        end
        else
        begin
            resp_valid <= resp_valid_next;
            resp_addr <= resp_addr_next;
            resp_target <= resp_target_next;
            resp_remapped <= resp_remapped_next;
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    sequence lower_data_req(logic [7:0] lo);
        req_valid && !req_fetch && req_addr[15:8] == 8'h00 && req_addr[7:0] >= lo;
    endsequence

    chk_win128_map: assert property (
        lower_data_req(8'h80) ##0 window_select_value[6:3] == 4'h2
        |=> resp_remapped && resp_addr == {6'h00, $past(window_select_value[2:0]),
            $past(req_addr[6:0])})
        else $error("128-byte window mapped wrongly");

    chk_win64_map: assert property (
        lower_data_req(8'hC0) ##0 window_select_value[6:4] == 3'h2
        |=> resp_addr == {6'h00, $past(window_select_value[3:0]), $past(req_addr[5:0])})
        else $error("64-byte window mapped wrongly");

    chk_win32_map: assert property (
        lower_data_req(8'hE0) ##0 window_select_value[6:5] == 2'h2
        |=> resp_addr == {6'h00, $past(window_select_value[4:0]), $past(req_addr[4:0])})
        else $error("32-byte window mapped wrongly");

    // A remapped address must still land in on-chip registers; block 0 may reach the SFRs.
    chk_window_in_ram: assert property (
        resp_valid && resp_remapped |-> resp_addr <= 16'h03FF
            && (resp_target == register_window_decoder_pkg::TGT_RAM
            || resp_target == register_window_decoder_pkg::TGT_SFR))
        else $error("Window left register RAM");

    chk_no_remap: assert property (
        req_valid && window_select_value[6:0] == 7'h00 |=> !resp_remapped
            && resp_addr == $past(req_addr))
        else $error("Remapped with no window selected");

    chk_prog_select: assert property (
        req_valid && req_addr >= 16'h2000 && req_addr <= 16'h9FFF && ext_sync_reg
        |=> resp_target == register_window_decoder_pkg::TGT_PROG)
        else $error("Program range not served on chip");

    chk_prog_off: assert property (
        req_valid && req_addr >= 16'h2000 && req_addr <= 16'h9FFF && !ext_sync_reg
        |=> resp_target == register_window_decoder_pkg::TGT_EXT)
        else $error("Program range not sent off chip");

    chk_high_ext: assert property (
        req_valid && req_addr >= 16'hA000 |=> resp_target == register_window_decoder_pkg::TGT_EXT)
        else $error("High range not external");

    chk_ram_region: assert property (
        resp_valid && !resp_remapped && resp_addr >= 16'h0018 && resp_addr <= 16'h03FF
        && $past(!req_fetch) |-> resp_target == register_window_decoder_pkg::TGT_RAM)
        else $error("RAM range misdecoded");

    chk_sfr_region: assert property (
        req_valid && !req_fetch && req_addr <= 16'h0017
        |=> resp_target == register_window_decoder_pkg::TGT_SFR)
        else $error("SPECIAL_FUNCTION_REGISTERS range misdecoded");

    chk_fetch_ext: assert property (
        req_valid && req_fetch && req_addr <= 16'h03FF
        |=> resp_target == register_window_decoder_pkg::TGT_EXT && !resp_remapped)
        else $error("Low fetch not external");

    chk_port_region: assert property (
        req_valid && req_addr >= 16'h1FFE && req_addr <= 16'h1FFF
        |=> resp_target == register_window_decoder_pkg::TGT_PORT34)
        else $error("Port range misdecoded");

    chk_ext_low: assert property (
        req_valid && req_addr >= 16'h0400 && req_addr <= 16'h1FFD
        |=> resp_target == register_window_decoder_pkg::TGT_EXT)
        else $error("Low external range misdecoded");

    // Every lower-file address under the lowest window base must pass through untouched.
    chk_below_window: assert property (
        req_valid && req_addr[15:8] == 8'h00 && req_addr[7:0] < 8'h80 |=> !resp_remapped)
        else $error("Address below the window remapped");

    // Any select outside the three patterns leaves the address alone, not only zero.
    chk_no_pattern: assert property (
        req_valid && window_select_value[6:3] != 4'h2 && window_select_value[6:4] != 3'h2
        && window_select_value[6:5] != 2'h2 |=> !resp_remapped && resp_addr == $past(req_addr))
        else $error("Remapped with no window pattern");

endmodule : register_window_decoder

// *** core_addr_model.sv ***
// Purpose: Core-side address path that presents requests to the decoder.
// Assumes: The caller invokes the tasks 1 ns after a rising edge of core_clk.
// Notes: When idle the address is inverted, so a stale request is never read as new.
`timescale 1ns/10ps
module core_addr_model (
    output logic req_valid,
    output logic req_fetch,
    output logic [7:0] window_select_value,
    output logic [15:0] req_addr
);
    // The program image keeps this reserved byte at a fixed value.
    logic [7:0] image_reserved_byte;
    initial
    begin
        image_reserved_byte = 8'h20;
        req_valid = 1'b0;
        req_fetch = 1'b0;
        window_select_value = 8'h00;
        req_addr = 16'h0000;
    end
    task automatic issue(input logic [7:0] sel, input logic [15:0] addr, input logic fetch);
        window_select_value = sel;
        req_addr = addr;
        req_fetch = fetch;
        req_valid = 1'b1;
    endtask : issue
    task automatic idle();
        req_valid = 1'b0;
        req_addr = ~req_addr;
    endtask : idle
endmodule : core_addr_model

// *** tb_register_window_decoder.sv ***
// Purpose: Self-checking bench for window remapping and the address map.
// Assumes: Inputs change 1 ns after the rising edge of core_clk.
// Notes: The access pin is held for 3 edges before use to cover its synchroniser.
`timescale 1ns/10ps
module tb_register_window_decoder;
    logic core_clk, sys_rst, external_access_select, req_valid, req_fetch;
    logic resp_valid, resp_remapped;
    logic [7:0] window_select_value;
    logic [15:0] req_addr, resp_addr;
    register_window_decoder_pkg::target_t resp_target;
    int n_mismatch, cmp_count, cycles;
    initial core_clk = 1'b0;
    always #4 core_clk = ~core_clk;
    register_window_decoder u_register_window_decoder (.core_clk(core_clk),
        .sys_rst(sys_rst), .window_select_value(window_select_value),
        .external_access_select(external_access_select), .req_valid(req_valid),
        .req_addr(req_addr), .req_fetch(req_fetch), .resp_valid(resp_valid),
        .resp_addr(resp_addr), .resp_target(resp_target), .resp_remapped(resp_remapped));
    core_addr_model u_core_addr_model (.req_valid(req_valid), .req_fetch(req_fetch),
        .window_select_value(window_select_value), .req_addr(req_addr));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // Expected target worked out from the address map, not from the design.
    function automatic logic [4:0] map_tgt(input logic [15:0] a, input logic ext,
        input logic fetch);
        if (fetch && a <= 16'h03FF) return 5'h10;
        if (a <= 16'h0017) return 5'h01;
        if (a <= 16'h03FF) return 5'h02;
        if (a <= 16'h1FFD) return 5'h10;
        if (a <= 16'h1FFF) return 5'h04;
        if (a <= 16'h9FFF) return ext ? 5'h08 : 5'h10;
        return 5'h10;
    endfunction : map_tgt
    task automatic access(input logic [7:0] sel, input logic [15:0] addr, input logic fetch,
        input logic [15:0] exp_addr, input logic exp_remap);
        u_core_addr_model.issue(sel, addr, fetch);
        @(posedge core_clk);
        #1;
        check({15'h0000, resp_valid}, 16'h0001);
        check(resp_addr, exp_addr);
        check({11'h000, resp_target}, {11'h000, map_tgt(exp_addr, external_access_select, fetch)});
        check({15'h0000, resp_remapped}, {15'h0000, exp_remap});
    endtask : access
    task automatic test_windows();
        for (int n = 0; n < 32; n++)
        begin
            if (n < 8)
            begin
                access({n[0], 4'h2, n[2:0]}, 16'h00FF, 1'b0,
                    {6'h00, n[2:0], 7'h7F}, 1'b1);
                access({n[0], 4'h2, n[2:0]}, 16'h007F, 1'b0, 16'h007F, 1'b0);
            end
            if (n < 16)
            begin
                access({n[0], 3'h2, n[3:0]}, 16'h00C0, 1'b0,
                    {6'h00, n[3:0], 6'h00}, 1'b1);
            end
            access({n[0], 2'h2, n[4:0]}, 16'h00E5, 1'b0,
                {6'h00, n[4:0], 5'h05}, 1'b1);
        end
    endtask : test_windows
    task automatic test_no_window();
        logic [7:0] sels [4] = '{8'h00, 8'h80, 8'h30, 8'h7F};
        foreach (sels[i]) access(sels[i], 16'h00FF, 1'b0, 16'h00FF, 1'b0);
        access(8'h10, 16'h0080, 1'b1, 16'h0080, 1'b0);
    endtask : test_no_window
    task automatic test_map();
        logic [15:0] addrs [15] = '{16'h0000, 16'h0017, 16'h0018, 16'h03FF, 16'h0400,
            16'h1FFD, 16'h1FFE, 16'h1FFF, 16'h2000, 16'h2080, 16'h9FFF, 16'hA000,
            16'hFFFF, 16'h0300, 16'h2019};
        check({8'h00, u_core_addr_model.image_reserved_byte}, 16'h0020);
        for (int p = 0; p < 2; p++)
        begin
            external_access_select = p[0];
            repeat (3) @(posedge core_clk);
            #1;
            foreach (addrs[i])
                access(8'h00, addrs[i], 1'b0,
                    addrs[i], 1'b0);
        end
        u_core_addr_model.idle();
        @(posedge core_clk);
        #1;
        check({15'h0000, resp_valid}, 16'h0000);
    endtask : test_map
    task automatic stop_test();
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : stop_test
    // A hang is cut short well above the 110 or so cycles the tests need.
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            n_mismatch++;
            stop_test();
        end
    end
    initial
    begin
        sys_rst = 1'b1;
        external_access_select = 1'b0;
        n_mismatch = 0;
        cmp_count = 0;
        cycles = 0;
        repeat (4) @(posedge core_clk);
        #1;
        sys_rst = 1'b0;
        test_windows();
        test_no_window();
        test_map();
        stop_test();
    end
endmodule : tb_register_window_decoder
